// *** hw/hmp_pkg.sv ***
// Purpose: Shared constants and types for the host memory port.
// Assumes: One 25 MHz clock; host strobes arrive asynchronously.
// Notes: Register offsets are data-space word addresses.
package hmp_pkg;
  // Bus and memory widths
  localparam int BUS_W = 16;
  localparam int ADDR_W = 14;
  localparam int PM_W = 24;
  localparam int OVL_W = 8;
  localparam int LOW_W = 8;
  localparam int SYNC_W = 20;

  // Register offsets in data space
  localparam logic [13:0] START_ADDR_OFS = 14'h3fe0;
  localparam logic [13:0] OVERLAY_OFS = 14'h3fe7;
  // Data-space control registers begin here and are host-write protected
  localparam logic [13:0] CTRL_BASE = 14'h3fe0;

  // Latch word fields
  localparam int OVL_SEL_BIT = 15;
  localparam int SPACE_BIT = 14;
  localparam int PM_HI_LSB = 8;

  // Memory space encoding of the space bit
  localparam logic SPACE_PM = 1'b0;
  localparam logic SPACE_DM = 1'b1;

  // Reset and step values
  localparam logic [13:0] ADDR_RESET = 14'h0000;
  localparam logic [13:0] ADDR_STEP = 14'h0001;
  localparam logic [13:0] BOOT_RELEASE_ADDR = 14'h0000;
  localparam logic [7:0] OVL_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [1:0] PAD_ZERO = 2'h0;

  // Boot mode pins {c, b, a} that select host port booting
  localparam logic [2:0] HOST_BOOT_MODE = 3'h5;

  // Synchroniser reset pattern: {sel_n, latch, rd_n, wr_n, bus}
  localparam logic [19:0] SYNC_RESET = 20'hb0000;

  // Access sequencer states
  typedef enum logic [2:0] {
    HMP_IDLE,
    HMP_SYNC,
    HMP_ACCESS,
    HMP_CAPTURE,
    HMP_HOLD
  } hmp_state_t;
endpackage : hmp_pkg

// *** hw/hmp_sync.sv ***
// Purpose: Three-stage synchroniser for asynchronous host pins.
// Assumes: Inputs may change at any time relative to clk.
// Notes: A bit's output follows only when stages two and three agree.
`timescale 1ns/100ps
module hmp_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  // One chain per bit; stage one feeds only stage two
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic out_reg;
      // Agreement filter rejects a single metastable resolution
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          s1_reg <= RESET_VAL[i];
          s2_reg <= RESET_VAL[i];
          s3_reg <= RESET_VAL[i];
          out_reg <= RESET_VAL[i];
        end else if (clk_en) begin
          s1_reg <= async_in[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            out_reg <= s3_reg;
          end
        end
      end
      assign sync_out[i] = out_reg;
    end
  endgenerate
endmodule : hmp_sync

// *** hw/hmp_port.sv ***
// Purpose: Host memory port: asynchronous host access to on-chip memory.
// Assumes: Memory returns read data the cycle after mem_req.
// Notes: Program words travel as two 16-bit transfers, high part first.
`timescale 1ns/100ps
// Behaviour
// [R1] One stolen cycle per word; control writes blocked
// [R2] Bit 15 high latches overlay from bits 7:0
// [R3] Bit 15 low latches address and space
// [R4] Host checks acknowledge before each operation
// [R5] 16-bit shared bus carries 24-bit program words
// [R6] Strobes synchronised; works at full speed
// [R7] Address increments after each completed access
// [R8] Address captured on latch strobe falling edge
// [R9] One sync cycle, then one access cycle
// [R10] Processor may write the start address register
// [R11] Overlay and address in separate mapped registers
// [R12] Host cannot read back latched address
// [R13] Boot pins 101 select host port boot
// [R14] Execution held until program location 0 written
// [R15] Program word: two transfers, then increment
// [R16] Acknowledge busy while an access is pending
module hmp_port (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic port_select_n,
  input wire logic address_latch_strobe,
  input wire logic port_read_strobe_n,
  input wire logic port_write_strobe_n,
  input wire logic [15:0] multiplexed_addr_data_in,
  output logic [15:0] multiplexed_addr_data_out,
  output logic multiplexed_addr_data_oe_n,
  output logic port_acknowledge_n,
  output logic mem_req,
  output logic mem_we,
  output logic mem_space,
  output logic [13:0] mem_addr,
  output logic [23:0] mem_wdata,
  input wire logic [23:0] mem_rdata,
  output logic [7:0] memory_overlay,
  input wire logic dsp_reg_wr,
  input wire logic dsp_reg_rd,
  input wire logic [13:0] dsp_reg_addr,
  input wire logic [15:0] dsp_reg_wdata,
  output logic [15:0] dsp_reg_rdata,
  input wire logic mode_a,
  input wire logic mode_b,
  input wire logic mode_c,
  output logic boot_hold
);
  // Register address decodes, shared by the write and read paths
  function automatic logic is_start_ofs(input logic [13:0] a);
    is_start_ofs = (a == hmp_pkg::START_ADDR_OFS);
  endfunction : is_start_ofs

  function automatic logic is_ovl_ofs(input logic [13:0] a);
    is_ovl_ofs = (a == hmp_pkg::OVERLAY_OFS);
  endfunction : is_ovl_ofs

  // Synchronised host pins
  logic [19:0] sync_q;
  logic sel_n_s; // Select, active low
  logic ial_s; // Address latch strobe
  logic rd_n_s; // Read strobe, active low
  logic wr_n_s; // Write strobe, active low
  logic [15:0] bus_s; // Bus value, already through three stages

  // Every pin, data included, goes through the same depth
  hmp_sync #(
    .WIDTH(hmp_pkg::SYNC_W),
    .RESET_VAL(hmp_pkg::SYNC_RESET)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .async_in({port_select_n, address_latch_strobe, port_read_strobe_n,
               port_write_strobe_n, multiplexed_addr_data_in}),
    .sync_out(sync_q)
  ); // see [R6]

  assign sel_n_s = sync_q[19];
  assign ial_s = sync_q[18];
  assign rd_n_s = sync_q[17];
  assign wr_n_s = sync_q[16];
  assign bus_s = sync_q[15:0];

  // State
  hmp_pkg::hmp_state_t state_reg, state_next;
  logic [13:0] addr_reg; // Current internal address
  logic space_reg; // Space selector, see package encoding
  logic [7:0] ovl_reg; // Overlay selection
  logic half_reg; // Second transfer of a program word pending
  logic op_rd_reg; // Access in flight is a read
  logic [15:0] wdata_reg; // Write word taken at access start
  logic [15:0] hi_reg; // Upper program bits from first transfer
  logic [7:0] lo_reg; // Low program byte kept for second read
  logic [15:0] rd_data_reg; // Word driven to the host
  logic [15:0] bus_prev_reg; // Bus value one cycle back
  logic lat_prev_reg; // Latch activity one cycle back
  logic rw_prev_reg; // Strobe activity one cycle back
  logic [15:0] dsp_rdata_reg; // Register read answer
  logic boot_hold_reg; // Processor held in host boot
  logic strap_done_reg; // Mode pins already sampled

  // Decode
  wire lat_act = !sel_n_s && ial_s;
  wire rd_act = !sel_n_s && !rd_n_s;
  wire wr_act = !sel_n_s && !wr_n_s;
  wire rw_act = rd_act || wr_act;
  wire idle = (state_reg == hmp_pkg::HMP_IDLE);
  // Latch is ignored while busy; the host must wait for acknowledge
  wire lat_commit = lat_prev_reg && !lat_act && idle; // see [R8] [R4]
  wire lat_ovl = bus_prev_reg[hmp_pkg::OVL_SEL_BIT];
  wire rw_start = rw_act && !rw_prev_reg && idle;
  wire is_pm = (space_reg == hmp_pkg::SPACE_PM);
  // Host writes never touch the control register block
  wire blocked = !is_pm && (addr_reg >= hmp_pkg::CTRL_BASE); // see [R1]
  wire word_done = !is_pm || half_reg; // see [R15]
  wire need_mem = op_rd_reg ? !(is_pm && half_reg)
                            : (word_done && !blocked);
  wire in_access = (state_reg == hmp_pkg::HMP_ACCESS);
  wire dsp_addr_wr = dsp_reg_wr && is_start_ofs(dsp_reg_addr);
  wire dsp_ovl_wr = dsp_reg_wr && is_ovl_ofs(dsp_reg_addr);
  wire boot_sel = ({mode_c, mode_b, mode_a} == hmp_pkg::HOST_BOOT_MODE);
  wire boot_write = mem_req && mem_we && is_pm &&
                    (addr_reg == hmp_pkg::BOOT_RELEASE_ADDR);

  // Sequencer: idle, one sync cycle, one access cycle, a capture cycle for reads only, then hold
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      hmp_pkg::HMP_IDLE: begin
        if (rw_start) begin
          state_next = hmp_pkg::HMP_SYNC;
        end
      end
      hmp_pkg::HMP_SYNC: begin
        state_next = hmp_pkg::HMP_ACCESS; // see [R9]
      end
      hmp_pkg::HMP_ACCESS: begin
        state_next = op_rd_reg ? hmp_pkg::HMP_CAPTURE : hmp_pkg::HMP_HOLD;
      end
      hmp_pkg::HMP_CAPTURE: begin
        state_next = hmp_pkg::HMP_HOLD;
      end
      hmp_pkg::HMP_HOLD: begin
        // Wait for strobe release so one strobe makes one access
        if (!rw_act) begin
          state_next = hmp_pkg::HMP_IDLE;
        end
      end
      default: begin
        state_next = hmp_pkg::HMP_IDLE;
      end
    endcase
  end

  // State register and edge history
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= hmp_pkg::HMP_IDLE;
      lat_prev_reg <= 1'b0;
      rw_prev_reg <= 1'b0;
      bus_prev_reg <= hmp_pkg::WORD_ZERO;
    end else if (clk_en) begin
      state_reg <= state_next;
      lat_prev_reg <= lat_act;
      rw_prev_reg <= rw_act;
      bus_prev_reg <= bus_s;
    end
  end

  // Start address: host latch beats processor write, which beats step
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      addr_reg <= hmp_pkg::ADDR_RESET;
      space_reg <= hmp_pkg::SPACE_PM;
      half_reg <= 1'b0;
    end else if (clk_en) begin
      if (lat_commit && !lat_ovl) begin
        addr_reg <= bus_prev_reg[13:0]; // see [R3] [R8]
        space_reg <= bus_prev_reg[hmp_pkg::SPACE_BIT];
        half_reg <= 1'b0;
      end else if (dsp_addr_wr) begin
        addr_reg <= dsp_reg_wdata[13:0]; // see [R10]
        space_reg <= dsp_reg_wdata[hmp_pkg::SPACE_BIT];
        half_reg <= 1'b0;
      end else if (in_access) begin
        half_reg <= is_pm && !half_reg; // see [R15] [R5]
        if (word_done) begin
          addr_reg <= addr_reg + hmp_pkg::ADDR_STEP; // see [R7]
        end
      end
    end
  end

  // Overlay register; upper bus bits are expected zero and not kept
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ovl_reg <= hmp_pkg::OVL_RESET;
    end else if (clk_en) begin
      if (lat_commit && lat_ovl) begin
        ovl_reg <= bus_prev_reg[7:0]; // see [R2]
      end else if (dsp_ovl_wr) begin
        ovl_reg <= dsp_reg_wdata[7:0]; // see [R11]
      end
    end
  end

  // Access data path
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      op_rd_reg <= 1'b0;
      wdata_reg <= hmp_pkg::WORD_ZERO;
      hi_reg <= hmp_pkg::WORD_ZERO;
      lo_reg <= hmp_pkg::BYTE_ZERO;
      rd_data_reg <= hmp_pkg::WORD_ZERO;
    end else if (clk_en) begin
      if (rw_start) begin
        op_rd_reg <= rd_act; // Read wins if both strobes low
        wdata_reg <= bus_s;
      end
      if (in_access && !op_rd_reg && is_pm && !half_reg) begin
        hi_reg <= wdata_reg; // see [R15]
      end
      if (state_reg == hmp_pkg::HMP_CAPTURE) begin
        if (is_pm && half_reg) begin
          lo_reg <= mem_rdata[7:0];
          rd_data_reg <= mem_rdata[23:8];
        end else if (is_pm) begin
          rd_data_reg <= {hmp_pkg::BYTE_ZERO, lo_reg};
        end else begin
          rd_data_reg <= mem_rdata[15:0];
        end
      end
    end
  end

  // Processor register reads; bit 15 of the address register reads zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dsp_rdata_reg <= hmp_pkg::WORD_ZERO;
    end else if (clk_en && dsp_reg_rd) begin
      if (is_start_ofs(dsp_reg_addr)) begin
        dsp_rdata_reg <= {1'b0, space_reg, addr_reg}; // see [R11]
      end else if (is_ovl_ofs(dsp_reg_addr)) begin
        dsp_rdata_reg <= {hmp_pkg::BYTE_ZERO, ovl_reg};
      end else begin
        dsp_rdata_reg <= hmp_pkg::WORD_ZERO;
      end
    end
  end

  // Boot strap sampled on the first enabled edge after reset release
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strap_done_reg <= 1'b0;
      boot_hold_reg <= 1'b1;
    end else if (clk_en) begin
      strap_done_reg <= 1'b1;
      if (!strap_done_reg) begin
        boot_hold_reg <= boot_sel; // see [R13]
      end else if (boot_write) begin
        boot_hold_reg <= 1'b0; // see [R14]
      end
    end
  end

  // Outputs; the port only ever returns memory data, never the address
  assign port_acknowledge_n = !idle; // see [R16]
  assign mem_req = in_access && need_mem; // see [R1] [R9]
  assign mem_we = !op_rd_reg;
  assign mem_space = space_reg;
  assign mem_addr = addr_reg;
  // Data word in program space joins the first transfer with the low byte
  assign mem_wdata = is_pm ? {hi_reg, wdata_reg[7:0]}
                           : {hmp_pkg::BYTE_ZERO, wdata_reg};
  assign multiplexed_addr_data_out = rd_data_reg; // see [R12]
  assign multiplexed_addr_data_oe_n =
    !((state_reg == hmp_pkg::HMP_HOLD) && op_rd_reg && rd_act);
  assign memory_overlay = ovl_reg;
  assign dsp_reg_rdata = dsp_rdata_reg;
  assign boot_hold = boot_hold_reg;

  // Checks, sampled on enabled edges only
  default clocking cb @(posedge clk iff clk_en);
  endclocking
  default disable iff (!resetn);

  one_steal_a: assert property (mem_req |=> !mem_req) // see [R1]
    else $error("more than one stolen cycle per access");
  ctrl_block_a: assert property (mem_req && mem_we |-> // see [R1]
    !(mem_space == hmp_pkg::SPACE_DM && mem_addr >= hmp_pkg::CTRL_BASE))
    else $error("host write reached control registers");
  ovl_take_a: assert property (lat_commit && lat_ovl |=> // see [R2]
    memory_overlay == $past(bus_prev_reg[hmp_pkg::OVL_W-1:0]))
    else $error("overlay not taken from latch");
  addr_take_a: assert property (lat_commit && !lat_ovl |=> // see [R3]
    mem_addr == $past(bus_prev_reg[hmp_pkg::ADDR_W-1:0]) &&
    mem_space == $past(bus_prev_reg[hmp_pkg::SPACE_BIT]) && !half_reg)
    else $error("start address not taken from latch");
  sync_step_a: assert property (rw_start |=> // see [R9]
    state_reg == hmp_pkg::HMP_SYNC ##1 in_access)
    else $error("access not after one sync cycle");
  addr_step_a: assert property (in_access && word_done && // see [R7]
    !lat_commit && !dsp_addr_wr |=>
    mem_addr == $past(mem_addr) + hmp_pkg::ADDR_STEP)
    else $error("address not incremented");
  pm_pair_a: assert property (in_access && is_pm && !half_reg && // see [R15]
    !lat_commit && !dsp_addr_wr |=> half_reg && $stable(mem_addr))
    else $error("program word split wrong");
  ack_busy_a: assert property (rw_start |=> // see [R16]
    port_acknowledge_n [*3])
    else $error("acknowledge not busy during access");
  dsp_wr_a: assert property (dsp_addr_wr && !lat_commit |=> // see [R10]
    mem_addr == $past(dsp_reg_wdata[hmp_pkg::ADDR_W-1:0]))
    else $error("processor address write lost");
  boot_free_a: assert property (boot_write && strap_done_reg |=> // see [R14]
    !boot_hold)
    else $error("boot hold not released");
  boot_sel_a: assert property (!strap_done_reg |=> // see [R13]
    boot_hold == $past(boot_sel))
    else $error("boot strap not sampled");

  read_cv: cover property (rw_start && rd_act ##3 !mem_we);
  write_cv: cover property (mem_req && mem_we && is_pm);
  latch_cv: cover property (lat_commit && !lat_ovl);
  boot_cv: cover property (boot_hold ##1 !boot_hold);
endmodule : hmp_port

// *** testbench/hmp_host_model.sv ***
// Purpose: Behavioural host that drives the port strobes and bus.
// Assumes: Port answers through acknowledge and the bus enable.
// Notes: Waits are bounded; an overrun raises hang.
`timescale 1ns/100ps
module hmp_host_model (
  input wire logic clk,
  input wire logic port_acknowledge_n,
  input wire logic multiplexed_addr_data_oe_n,
  input wire logic [15:0] read_bus,
  output logic port_select_n,
  output logic address_latch_strobe,
  output logic port_read_strobe_n,
  output logic port_write_strobe_n,
  output logic [15:0] host_bus,
  output logic hang
);
  // Idle pins; strobes inactive, bus parked
  initial begin
    port_select_n = 1'b1;
    address_latch_strobe = 1'b0;
    port_read_strobe_n = 1'b1;
    port_write_strobe_n = 1'b1;
    host_bus = 16'h0000;
    hang = 1'b0;
  end

  // Bounded wait on acknowledge or bus enable, looked at once settled
  task automatic await(input bit on_oe, input logic lvl);
    int n;
    n = 0;
    while (((on_oe ? multiplexed_addr_data_oe_n : port_acknowledge_n)
            !== lvl) && n < 40) begin
      @(posedge clk);
      #2;
      n++;
    end
    if (n >= 40) begin
      hang = 1'b1;
    end
  endtask : await

  // Latch cycle; word held steady across the whole strobe
  task automatic latch_word(input logic [15:0] w);
    await(1'b0, 1'b0);
    @(posedge clk);
    #2;
    host_bus = w;
    port_select_n = 1'b0;
    address_latch_strobe = 1'b1;
    repeat (6) @(posedge clk);
    #2;
    address_latch_strobe = 1'b0;
    port_select_n = 1'b1;
    // Released bus shows the inverse, never the old value
    host_bus = ~w;
    repeat (6) @(posedge clk);
    #2;
  endtask : latch_word

  // One 16-bit transfer; request held until the port answers busy, and for a read until it drives the bus
  task automatic xfer(input logic rd, input logic [15:0] w,
                      output logic [15:0] r);
    await(1'b0, 1'b0);
    r = 16'h0000;
    host_bus = w;
    port_select_n = 1'b0;
    port_read_strobe_n = ~rd;
    port_write_strobe_n = rd;
    await(1'b0, 1'b1);
    if (rd) begin
      await(1'b1, 1'b0);
      r = read_bus;
    end
    port_select_n = 1'b1;
    port_read_strobe_n = 1'b1;
    port_write_strobe_n = 1'b1;
    host_bus = ~w;
    await(1'b0, 1'b0);
  endtask : xfer
endmodule : hmp_host_model

// *** testbench/host_internal_memory_dma_port_tb_top.sv ***
// Purpose: Self-checking bench for the host memory port.
// Assumes: Memory model answers the cycle after each request.
// Notes: Clock enable drops once to show that state freezes.
`timescale 1ns/100ps
module host_internal_memory_dma_port_tb_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic sel_n, latch, rd_n, wr_n, oe_n, ack_n, hang, boot_hold;
  logic [15:0] host_bus, dut_bus, bus_in, rdata, r;
  logic mem_req, mem_we, mem_space;
  logic [13:0] mem_addr;
  logic [23:0] mem_wdata;
  logic [23:0] mem_rdata = 24'h000000;
  logic [7:0] ovl;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [13:0] reg_addr = 14'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic [2:0] mode = 3'h5;
  logic clk_en = 1'b1; // Dropped only by the freeze scenario
  logic [23:0] mem [0:32767]; // Indexed {space, address}
  int fails = 0;
  int num_checks = 0;
  int nreq = 0;
  int cycles = 0;

  // Clock, 40 ns period
  initial begin
    forever #20 clk = ~clk;
  end

  // Bus wire: device wins only while it drives
  assign bus_in = oe_n ? host_bus : dut_bus;

  hmp_host_model host (.clk(clk), .port_acknowledge_n(ack_n),
    .multiplexed_addr_data_oe_n(oe_n), .read_bus(bus_in),
    .port_select_n(sel_n), .address_latch_strobe(latch),
    .port_read_strobe_n(rd_n), .port_write_strobe_n(wr_n),
    .host_bus(host_bus), .hang(hang));

  hmp_port dut (.clk(clk), .resetn(resetn), .clk_en(clk_en),
    .port_select_n(sel_n), .address_latch_strobe(latch),
    .port_read_strobe_n(rd_n), .port_write_strobe_n(wr_n),
    .multiplexed_addr_data_in(bus_in),
    .multiplexed_addr_data_out(dut_bus),
    .multiplexed_addr_data_oe_n(oe_n), .port_acknowledge_n(ack_n),
    .mem_req(mem_req), .mem_we(mem_we), .mem_space(mem_space),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .memory_overlay(ovl), .dsp_reg_wr(reg_wr), .dsp_reg_rd(reg_rd),
    .dsp_reg_addr(reg_addr), .dsp_reg_wdata(reg_wdata),
    .dsp_reg_rdata(rdata), .mode_a(mode[0]), .mode_b(mode[1]),
    .mode_c(mode[2]), .boot_hold(boot_hold));

  // Memory model; counts every stolen cycle
  always @(posedge clk) begin
    if (mem_req === 1'b1) begin
      nreq++;
      if (mem_we) begin
        mem[{mem_space, mem_addr}] = mem_wdata;
      end else begin
        mem_rdata <= mem[{mem_space, mem_addr}];
      end
    end
  end

  // Cycle ceiling; the whole run needs a few hundred
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      fails++;
      tally_and_finish();
    end
  end

  function automatic logic [23:0] peek(input logic [14:0] k);
    // Unwritten words read unknown, so a lost write never passes
    return mem[k];
  endfunction : peek

  task automatic check(input string what, input logic [23:0] seen,
                       input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic reg_write(input logic [13:0] a, input logic [15:0] d);
    @(posedge clk);
    #2;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #2;
    reg_wr = 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [13:0] a, output logic [15:0] d);
    @(posedge clk);
    #2;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #2;
    reg_rd = 1'b0;
    d = rdata;
  endtask : reg_read

  task automatic do_reset(input logic [2:0] m);
    mode = m;
    resetn = 1'b0;
    repeat (12) @(posedge clk);
    #2;
    resetn = 1'b1;
    repeat (3) @(posedge clk);
    #2;
  endtask : do_reset

  // Every strap pattern; only 101 holds execution for the port
  task automatic t_boot_modes;
    logic [15:0] d;
    for (int m = 0; m < 8; m++) begin
      do_reset(m[2:0]);
      check("boot_hold", boot_hold, {23'h0, m[2:0] == 3'h5});
    end
    do_reset(3'h5);
    check("ack idle", ack_n, 24'h0);
    check("bus released", oe_n, 24'h1);
    reg_read(hmp_pkg::START_ADDR_OFS, d);
    check("start reset", d, 24'h0);
    reg_read(14'h3fe5, d);
    check("unmapped read", d, 24'h0);
    $display("test boot_modes done");
  endtask : t_boot_modes

  // Data-space block write then read back from one start address
  task automatic t_data_stream;
    int n0;
    logic [15:0] w;
    logic [14:0] k;
    n0 = nreq;
    host.latch_word(16'h4100);
    for (int i = 0; i < 3; i++) begin
      w = 16'h1230 + 16'(i);
      host.xfer(1'h0, w, r);
    end
    for (int i = 0; i < 3; i++) begin
      w = 16'h1230 + 16'(i);
      k = 15'h4100 + 15'(i);
      check("dm word", peek(k), {8'h00, w});
    end
    check("steals", 24'(nreq - n0), 24'h000003);
    check("still held", boot_hold, 24'h1);
    reg_read(hmp_pkg::START_ADDR_OFS, r);
    check("start after", r, 24'h4103);
    host.latch_word(16'h4100);
    for (int i = 0; i < 3; i++) begin
      host.xfer(1'h1, 16'h0000, r);
      w = 16'h1230 + 16'(i);
      check("dm read", r, {8'h00, w});
    end
    $display("test data_stream done");
  endtask : t_data_stream

  // Program word in two transfers; location 0 releases boot
  task automatic t_program_word;
    host.latch_word(16'h0000);
    host.xfer(1'h0, 16'habcd, r);
    check("half word held", boot_hold, 24'h1);
    host.xfer(1'h0, 16'h00ef, r);
    check("pm word", peek(15'h0000), 24'habcdef);
    check("boot release", boot_hold, 24'h0);
    reg_read(hmp_pkg::START_ADDR_OFS, r);
    check("pm step", r, 24'h0001);
    host.latch_word(16'h0000);
    host.xfer(1'h1, 16'h0000, r);
    check("pm high", r, 24'habcd);
    host.xfer(1'h1, 16'h0000, r);
    check("pm low", r, 24'h00ef);
    $display("test program_word done");
  endtask : t_program_word

  // Overlay latch leaves the start address alone
  task automatic t_overlay;
    host.latch_word(16'h805a);
    check("overlay", ovl, 24'h5a);
    reg_read(hmp_pkg::OVERLAY_OFS, r);
    check("overlay reg", r, 24'h005a);
    reg_read(hmp_pkg::START_ADDR_OFS, r);
    check("start kept", r, 24'h0001);
    reg_write(hmp_pkg::OVERLAY_OFS, 16'h0033);
    check("overlay write", ovl, 24'h33);
    $display("test overlay done");
  endtask : t_overlay

  // Control area refuses host writes; processor sets start address
  task automatic t_protect;
    int n0;
    reg_write(hmp_pkg::START_ADDR_OFS, 16'h7fe0);
    n0 = nreq;
    host.xfer(1'h0, 16'hbeef, r);
    check("no steal", 24'(nreq - n0), 24'h000000);
    reg_read(hmp_pkg::START_ADDR_OFS, r);
    check("step anyway", r, 24'h7fe1);
    reg_write(hmp_pkg::START_ADDR_OFS, 16'h4200);
    host.xfer(1'h0, 16'h55aa, r);
    check("dsp start", peek(15'h4200), 24'h0055aa);
    check("handshake", hang, 24'h0);
    $display("test protect done");
  endtask : t_protect

  // Frozen clock enable: a processor write in that window must not land
  task automatic t_freeze;
    clk_en = 1'b0;
    reg_write(hmp_pkg::START_ADDR_OFS, 16'h4444);
    clk_en = 1'b1;
    reg_read(hmp_pkg::START_ADDR_OFS, r);
    check("frozen write", r, 24'h4201);
    $display("test freeze done");
  endtask : t_freeze

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // Main sequence
  initial begin
    t_boot_modes();
    t_data_stream();
    t_program_word();
    t_overlay();
    t_protect();
    t_freeze();
    tally_and_finish();
  end
endmodule : host_internal_memory_dma_port_tb_top
